// ===== src/cal_timer.sv
// Calendar timer with clock and compare modes behind an AXI4-Lite slave
//
// Behaviour
// (RL1) Clock mode: div2, 4-bit, 8-bit make seconds
// (RL2) Run bit one starts, zero stops
// (RL3) Clock-mode interrupt timing selected by software
// (RL4) Separate enables: week, day, hour, minute, second
// (RL5) Clock mode pin: port or f2/f4/f8
// (RL6) Time registers read live, BCD values
// (RL7) Time writes only while stopped, BCD
// (RL8) Hours in 12-hour or 24-hour form
// (RL9) Compare mode: source/2, optional prescaler, 8-bit
// (RL10) Compare source: f4, f8, f32, slow
// (RL11) Match clears counter; stopped counter holds
// (RL12) Period 2(n+1) or 32(n+1) source cycles
// (RL13) Interrupt request on every compare match
// (RL14) Compare mode pin: port, f2/f4/f8, compare
// (RL15) Compare mode reads: counter and compare value
// (RL16) Seconds writes ignored; compare written while stopped
// (RL17) Compare output toggles on each match
// (RL18) Compare output low after any reset
// (RL19) Stopping holds the compare output level
// (RL20) Running flag follows run bit within 2 cycles; here it follows on the next count-source tick
// (RL21) Seconds, minutes roll 59; hours, weekday wrap
`timescale 1ns/1ps
`default_nettype none
`include "cal_defines.svh"
module cal_timer
  import cal_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Slow count source, one-cycle enable pulses
  input  wire logic        slow_clock_source,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  // Timer pin and interrupt request
  output var  logic        timer_output_pin,
  output var  logic        timer_irq
);

  // Software-visible state
  logic [7:0]  seconds_counter_reg;
  logic [7:0]  minutes_compare_reg;
  logic [7:0]  hours_reg;
  logic [2:0]  weekday_reg;
  logic        count_run_request;
  logic        count_running_flag;
  logic        h12_mode;
  logic        pm_flag;
  logic [5:0]  timer_control_two;
  logic [7:0]  count_source_select_reg;
  // Dividers and bus bookkeeping
  logic [4:0]  sys_div;
  logic        half_div;
  logic [3:0]  prescale_cnt;
  logic [7:0]  sec_div;
  logic        cmp_out;
  logic        aw_have;
  logic        w_have;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;

  // Field views of the selection register
  cal_mode_type mode;
  cal_src_type  src_sel;
  cal_pin_type  pin_sel;
  wire          prescale_counter_use =
    count_source_select_reg[`CAL_SS_PRESCALE];
  assign mode    = cal_mode_type'(count_source_select_reg[`CAL_SS_MODE]);
  assign src_sel =
    cal_src_type'(count_source_select_reg[`CAL_SS_SRC_LSB +: 2]);
  assign pin_sel =
    cal_pin_type'(count_source_select_reg[`CAL_SS_PIN_LSB +: 2]);
  wire compare_mode = (mode == CAL_MODE_COMPARE);

  // System clock fractions; f1 is ref_clk itself
  wire f4_en  = (sys_div[1:0] == 2'h3);
  wire f8_en  = (sys_div[2:0] == 3'h7);
  wire f32_en = (sys_div == 5'h1F);

  // Count source: clock mode always uses the slow source
  wire src_tick = !compare_mode ? slow_clock_source : // RL1
                  (src_sel == CAL_SRC_F4)  ? f4_en  : // RL10
                  (src_sel == CAL_SRC_F8)  ? f8_en  :
                  (src_sel == CAL_SRC_F32) ? f32_en : slow_clock_source;

  // Divider chain; the prescaler is skipped only in compare mode
  wire counting   = count_running_flag && count_run_request; // RL2
  wire half_tick  = counting && src_tick && half_div;
  wire use_pre    = !compare_mode || prescale_counter_use; // RL9
  wire pre_wrap   = (prescale_cnt == `CAL_PRESCALE_MAX);
  wire eight_tick = half_tick && (!use_pre || pre_wrap);
  wire sec_tick   = !compare_mode && eight_tick &&
                    (sec_div == `CAL_SEC_DIV_MAX); // RL1
  wire cmp_match  = compare_mode && eight_tick &&
                    (sec_div == minutes_compare_reg); // RL11

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // Calendar carries
  wire sec_wrap  = (seconds_counter_reg == `CAL_BCD_59);
  wire min_tick  = sec_tick && sec_wrap;
  wire min_wrap  = (minutes_compare_reg == `CAL_BCD_59);
  wire hr_tick   = min_tick && min_wrap;
  wire hr_wrap   = h12_mode ? (hours_reg == `CAL_BCD_11)
                            : (hours_reg == `CAL_BCD_23); // RL8
  wire day_tick  = hr_tick && hr_wrap && (!h12_mode || pm_flag);
  wire wk_wrap   = (weekday_reg == `CAL_WEEK_LAST);
  wire week_tick = day_tick && wk_wrap;

  // Interrupt request from the selected clock events and every compare match
  wire clk_irq = (sec_tick  && timer_control_two[`CAL_C2_SEC_IE])  ||
                 (min_tick  && timer_control_two[`CAL_C2_MIN_IE])  ||
                 (hr_tick   && timer_control_two[`CAL_C2_HR_IE])   ||
                 (day_tick  && timer_control_two[`CAL_C2_DAY_IE])  ||
                 (week_tick && timer_control_two[`CAL_C2_WEEK_IE]); // RL4
  wire next_irq = clk_irq || cmp_match; // RL3 RL13

  // Bus write decode; apart from the run and soft-reset bits, registers change only while fully stopped
  wire wr_go    = aw_have && w_have && !s_axi_bvalid;
  wire stopped  = !count_run_request && !count_running_flag;
  wire wr_lane  = wr_go && s_axi_wstrb[0];
  wire wr_hit   = (wr_addr[1:0] == 2'h0) && (wr_addr <= `CAL_OFF_SRC_SEL);
  wire wr_sec   = wr_lane && stopped && !compare_mode
                  && (wr_addr == `CAL_OFF_SECONDS); // RL7 RL16
  wire wr_min   = wr_lane && stopped && (wr_addr == `CAL_OFF_MINUTES); // RL16
  wire wr_hr    = wr_lane && stopped && (wr_addr == `CAL_OFF_HOURS); // RL7
  wire wr_wk    = wr_lane && stopped && (wr_addr == `CAL_OFF_WEEKDAY);
  wire wr_c1    = wr_lane && (wr_addr == `CAL_OFF_CTRL_ONE);
  wire wr_c2    = wr_lane && stopped && (wr_addr == `CAL_OFF_CTRL_TWO);
  wire wr_ss    = wr_lane && stopped && (wr_addr == `CAL_OFF_SRC_SEL);
  wire soft_rst = wr_c1 && wr_data[`CAL_C1_SOFT_RST];
  wire tmr_rst  = srst || soft_rst;

  // Read multiplexer; compare mode reuses seconds and minutes
  wire [7:0] ctrl_one_rd = {2'h0, pm_flag, h12_mode, 2'h0,
                            count_running_flag, count_run_request};
  wire rd_hit = (s_axi_araddr == `CAL_OFF_SECONDS) ||
                (s_axi_araddr == `CAL_OFF_MINUTES) ||
                (s_axi_araddr == `CAL_OFF_HOURS)   ||
                (s_axi_araddr == `CAL_OFF_WEEKDAY) ||
                (s_axi_araddr == `CAL_OFF_CTRL_ONE) ||
                (s_axi_araddr == `CAL_OFF_CTRL_TWO) ||
                (s_axi_araddr == `CAL_OFF_SRC_SEL);
  wire [7:0] rd_byte =
    (s_axi_araddr == `CAL_OFF_SECONDS) ?
      (compare_mode ? sec_div : seconds_counter_reg) : // RL6 RL15
    (s_axi_araddr == `CAL_OFF_MINUTES) ? minutes_compare_reg : // RL15
    (s_axi_araddr == `CAL_OFF_HOURS)   ? hours_reg :
    (s_axi_araddr == `CAL_OFF_WEEKDAY) ? {5'h00, weekday_reg} :
    (s_axi_araddr == `CAL_OFF_CTRL_ONE) ? ctrl_one_rd :
    (s_axi_araddr == `CAL_OFF_CTRL_TWO) ? {2'h0, timer_control_two} :
    (s_axi_araddr == `CAL_OFF_SRC_SEL) ? count_source_select_reg : 8'h00;

  // Pin level selection
  wire next_pin =
    (compare_mode && timer_control_two[`CAL_C2_CMP_OUT_EN]) ? cmp_out : // RL14
    (pin_sel == CAL_PIN_F2) ? sys_div[0] :
    (pin_sel == CAL_PIN_F4) ? sys_div[1] :
    (pin_sel == CAL_PIN_F8) ? sys_div[2] :
    count_source_select_reg[`CAL_SS_GPIO_VAL]; // RL5

  // Free-running system divider
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sys_div <= 5'h00;
    end else begin
      sys_div <= sys_div + 5'h01;
    end
  end

  // Run request and running flag; the flag tracks on a source tick
  always_ff @(posedge ref_clk) begin
    if (tmr_rst) begin
      count_run_request  <= 1'b0;
      count_running_flag <= 1'b0;
    end else begin
      if (wr_c1) begin
        count_run_request <= wr_data[`CAL_C1_RUN]; // RL2
      end
      if (src_tick) begin
        count_running_flag <= count_run_request; // RL20
      end
    end
  end

  // Mode and configuration bits, writable while stopped
  always_ff @(posedge ref_clk) begin
    if (tmr_rst) begin
      h12_mode                <= 1'b0;
      timer_control_two       <= 6'h00;
      count_source_select_reg <= `CAL_RST_BYTE;
    end else begin
      if (wr_c1 && stopped) begin
        h12_mode <= wr_data[`CAL_C1_H12]; // RL8
      end
      if (wr_c2) begin
        timer_control_two <= wr_data[5:0];
      end
      if (wr_ss) begin
        count_source_select_reg <= wr_data[7:0];
      end
    end
  end

  // Divide-by-two stage, prescaler and 8-bit counter
  always_ff @(posedge ref_clk) begin
    if (tmr_rst) begin
      half_div     <= 1'b0;
      prescale_cnt <= 4'h0;
      sec_div      <= 8'h00;
    end else if (counting && src_tick) begin // RL11
      half_div <= !half_div; // RL12
      if (half_tick && use_pre) begin
        prescale_cnt <= prescale_cnt + 4'h1;
      end
      if (cmp_match) begin
        sec_div <= 8'h00; // RL11
      end else if (eight_tick) begin
        sec_div <= sec_div + 8'h01;
      end
    end
  end

  // Seconds and minutes, or compare value in compare mode
  always_ff @(posedge ref_clk) begin
    if (tmr_rst) begin
      seconds_counter_reg <= `CAL_RST_BYTE;
      minutes_compare_reg <= `CAL_RST_BYTE;
    end else begin
      if (wr_sec) begin
        seconds_counter_reg <= wr_data[7:0];
      end else if (sec_tick) begin
        seconds_counter_reg <= sec_wrap ? 8'h00
                                        : bcd_inc(seconds_counter_reg); // RL21
      end
      if (wr_min) begin
        minutes_compare_reg <= wr_data[7:0];
      end else if (min_tick) begin
        minutes_compare_reg <= min_wrap ? 8'h00
                                        : bcd_inc(minutes_compare_reg); // RL21
      end
    end
  end

  // Hours, afternoon flag and weekday
  always_ff @(posedge ref_clk) begin
    if (tmr_rst) begin
      hours_reg   <= `CAL_RST_BYTE;
      pm_flag     <= 1'b0;
      weekday_reg <= `CAL_RST_WEEKDAY;
    end else begin
      if (wr_hr) begin
        hours_reg <= wr_data[7:0];
      end else if (hr_tick) begin
        hours_reg <= hr_wrap ? 8'h00 : bcd_inc(hours_reg); // RL8 RL21
      end
      if (wr_c1 && stopped) begin
        pm_flag <= wr_data[`CAL_C1_PM];
      end else if (hr_tick && hr_wrap && h12_mode) begin
        pm_flag <= !pm_flag;
      end
      if (wr_wk) begin
        weekday_reg <= wr_data[2:0];
      end else if (day_tick) begin
        weekday_reg <= wk_wrap ? 3'h0 : weekday_reg + 3'h1; // RL21
      end
    end
  end

  // Compare output; stopping leaves it where it stands
  always_ff @(posedge ref_clk) begin
    if (tmr_rst) begin
      cmp_out <= 1'b0; // RL18
    end else if (cmp_match) begin
      cmp_out <= !cmp_out; // RL17 RL19
    end
  end

  // Registered pin and interrupt pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_output_pin <= 1'b0;
      timer_irq        <= 1'b0;
    end else begin
      timer_output_pin <= next_pin;
      timer_irq        <= next_irq;
    end
  end

  // Write channel: address and data accepted in either order
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CAL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        wr_data      <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CAL_RESP_OKAY : `CAL_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: one outstanding read, answered the next cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CAL_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_hit ? `CAL_RESP_OKAY : `CAL_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== inc/cal_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CAL_DEFINES_SVH
`define CAL_DEFINES_SVH
// Byte offsets on the register bus
`define CAL_OFF_SECONDS     8'h00
`define CAL_OFF_MINUTES     8'h04
`define CAL_OFF_HOURS       8'h08
`define CAL_OFF_WEEKDAY     8'h0C
`define CAL_OFF_CTRL_ONE    8'h10
`define CAL_OFF_CTRL_TWO    8'h14
`define CAL_OFF_SRC_SEL     8'h18
// Fields of timer_control_one
`define CAL_C1_RUN          0
`define CAL_C1_RUNNING      1
`define CAL_C1_SOFT_RST     2
`define CAL_C1_H12          4
`define CAL_C1_PM           5
// Fields of timer_control_two
`define CAL_C2_SEC_IE       0
`define CAL_C2_MIN_IE       1
`define CAL_C2_HR_IE        2
`define CAL_C2_DAY_IE       3
`define CAL_C2_WEEK_IE      4
`define CAL_C2_CMP_OUT_EN   5
// Fields of count_source_select_reg
`define CAL_SS_SRC_LSB      0
`define CAL_SS_PRESCALE     2
`define CAL_SS_PIN_LSB      4
`define CAL_SS_MODE         6
`define CAL_SS_GPIO_VAL     7
// Reset values
`define CAL_RST_BYTE        8'h00
`define CAL_RST_WEEKDAY     3'h0
// Divider lengths: two stages, 4-bit prescaler and 8-bit counter
`define CAL_PRESCALE_MAX    4'hF
`define CAL_SEC_DIV_MAX     8'hFF
// Calendar limits in BCD
`define CAL_BCD_59          8'h59
`define CAL_BCD_23          8'h23
`define CAL_BCD_11          8'h11
`define CAL_WEEK_LAST       3'h6
// Bus answers
`define CAL_RESP_OKAY       2'h0
`define CAL_RESP_DECERR     2'h3
`endif

// ===== inc/cal_pkg.sv
// Types shared by the calendar timer
package cal_pkg;
  typedef enum logic {CAL_MODE_CLOCK = 1'b0, CAL_MODE_COMPARE = 1'b1}
    cal_mode_type;
  typedef enum logic [1:0] {
    CAL_SRC_F4 = 2'h0, CAL_SRC_F8 = 2'h1, CAL_SRC_F32 = 2'h2,
    CAL_SRC_SLOW = 2'h3
  } cal_src_type;
  typedef enum logic [1:0] {
    CAL_PIN_GPIO = 2'h0, CAL_PIN_F2 = 2'h1, CAL_PIN_F4 = 2'h2,
    CAL_PIN_F8 = 2'h3
  } cal_pin_type;
endpackage

// ===== test/cal_timer_assertions.sv
// Port-level checks for the calendar timer
`timescale 1ns/1ps
`default_nettype none
module cal_timer_checker (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Timer pin and request
  input wire logic        timer_output_pin,
  input wire logic        timer_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Address and data taken on one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER:
    assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  AST_RD_ANSWER:
    assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_B_DONE:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_R_UPPER:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_DECERR:
    assert property (rd_taken and s_axi_araddr > 8'h1B |=>
      s_axi_rresp == 2'h3 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  AST_IRQ_PULSE:
    assert property (timer_irq |=> !timer_irq)
    else $error("request wider than one cycle");
  AST_RESET_PIN:
    assert property ($fell(srst) |-> !timer_output_pin && !timer_irq)
    else $error("pin or request high after reset");
endmodule
`default_nettype wire

// ===== test/cal_timer_tb.sv
// Register-level bench for the calendar timer
`timescale 1ns/1ps
`default_nettype none
`include "cal_defines.svh"
module cal_timer_tb;
  localparam logic [7:0] o_sec = `CAL_OFF_SECONDS;
  localparam logic [7:0] o_min = `CAL_OFF_MINUTES;
  localparam logic [7:0] o_hr  = `CAL_OFF_HOURS;
  localparam logic [7:0] o_wk  = `CAL_OFF_WEEKDAY;
  localparam logic [7:0] o_c1  = `CAL_OFF_CTRL_ONE;
  localparam logic [7:0] o_c2  = `CAL_OFF_CTRL_TWO;
  localparam logic [7:0] o_ss  = `CAL_OFF_SRC_SEL;
  // Compare setups: source, prescaler and expected period (n = 3)
  localparam logic [7:0] cfg [5] = '{8'h43, 8'h40, 8'h41, 8'h42, 8'h47};
  localparam int         per [5] = '{8, 32, 64, 256, 128};
  logic        ref_clk, srst, slow_clock_source;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic   s_axi_arready, s_axi_rvalid;
  wire logic   timer_output_pin, timer_irq;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t0, i;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic        p;

  cal_timer cal_timer_inst (
    .ref_clk, .srst, .slow_clock_source,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .timer_output_pin, .timer_irq
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cycle count; also cuts a hung run short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      close_out;
    end
  end

  // Write: address and data offered together, each dropped when taken
  // Waits only on the answer; the cycle ceiling ends a hang
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    chk(rd, e);
  endtask

  // Set or clear the run request, then poll the running flag
  // The hour-form bits ride along, since a stopped write also sets them
  task run(input logic v, input logic [1:0] hb = 2'h0);
    wr(o_c1, {26'h0, hb, 3'h0, v});
    for (int n = 0; n < 100; n++) begin
      rd_reg(o_c1);
      if (rd[1] === v) break;
    end
    chk(rd[1:0], {v, v});
  endtask

  // Wait for the next request pulse; the cycle ceiling ends a hang
  task wait_irq;
    do begin
      @(posedge ref_clk);
    end while (timer_irq !== 1'b1);
  endtask

  initial begin
    srst = 1'b1;
    slow_clock_source = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    // Every register clear, unmapped places refused
    for (i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
    rchk(8'h1C, 32'h0);
    chk(rs, 32'h3);
    wr(8'h20, 32'h5);
    chk(rs, 32'h3);
    chk(timer_output_pin, 1'b0);
    wr(o_ss, 32'h10);
    @(posedge ref_clk);
    p = timer_output_pin;
    @(posedge ref_clk);
    chk(timer_output_pin, !p);
    wr(o_ss, 32'h80);
    repeat (3) @(posedge ref_clk);
    chk(timer_output_pin, 1'b1);
    wr(o_ss, 32'h00);
    $display("test reset and port pin done");
    // Saturday 23:59:58, minute request only
    wr(o_sec, 32'h58);
    wr(o_min, 32'h59);
    wr(o_hr, 32'h23);
    wr(o_wk, 32'h6);
    wr(o_c2, 32'h02);
    rchk(o_sec, 32'h58);
    run(1'b1);
    t0 = cyc;
    wr(o_sec, 32'h30);
    wait_irq;
    chk(cyc - t0 > 8192, 1'b1);
    run(1'b0);
    rchk(o_sec, 32'h00);
    rchk(o_min, 32'h00);
    rchk(o_hr, 32'h00);
    rchk(o_wk, 32'h0);
    $display("test clock mode done");
    // Saturday 11:59:59 afternoon in 12-hour form, weekly request only
    wr(o_c1, 32'h30);
    wr(o_hr, 32'h11);
    wr(o_min, 32'h59);
    wr(o_sec, 32'h59);
    wr(o_wk, 32'h6);
    wr(o_c2, 32'h10);
    rchk(o_c1, 32'h30);
    run(1'b1, 2'h3);
    wait_irq;
    run(1'b0);
    rchk(o_hr, 32'h00);
    rchk(o_c1, 32'h10);
    rchk(o_min, 32'h00);
    rchk(o_wk, 32'h0);
    $display("test twelve-hour mode done");
    // Compare mode from a soft reset
    wr(o_c1, 32'h04);
    rchk(o_c2, 32'h0);
    chk(timer_output_pin, 1'b0);
    wr(o_min, 32'h03);
    wr(o_ss, 32'h40);
    wr(o_sec, 32'h55);
    rchk(o_sec, 32'h00);
    rchk(o_min, 32'h03);
    wr(o_c2, 32'h20);
    for (i = 0; i < 5; i++) begin
      wr(o_ss, {24'h0, cfg[i]});
      run(1'b1);
      wait_irq;
      t0 = cyc;
      p = timer_output_pin;
      wait_irq;
      chk(cyc - t0, per[i]);
      chk(timer_output_pin, !p);
      run(1'b0);
      p = timer_output_pin;
      rd_reg(o_sec);
      t0 = rd;
      repeat (300) @(posedge ref_clk);
      rchk(o_sec, t0);
      chk(timer_output_pin, p);
    end
    // Stop just after a rising toggle so the soft reset has work to do
    run(1'b1);
    while (timer_output_pin !== 1'b0) @(posedge ref_clk);
    while (timer_output_pin !== 1'b1) @(posedge ref_clk);
    run(1'b0);
    chk(timer_output_pin, 1'b1);
    wr(o_c1, 32'h04);
    wr(o_ss, 32'h40);
    wr(o_c2, 32'h20);
    repeat (2) @(posedge ref_clk);
    chk(timer_output_pin, 1'b0);
    $display("test compare mode done");
    close_out;
  end
endmodule

bind cal_timer cal_timer_checker cal_timer_checker_inst (
  .ref_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .timer_output_pin,
  .timer_irq
);
`default_nettype wire
